// *** rtl/bst_od_clamp.sv ***
`timescale 1ns/10ps
`default_nettype none
module bst_od_clamp
#(
	parameter int CYC_PER_MS = bst_pkg::CYC_PER_MS
)
(
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [1:0] clamp_code,
	input  wire logic       calib_active,
	input  wire logic       diag_active,
	input  wire logic       od_active,
	output logic            rated_clamp
);
	localparam int CW = bst_pkg::CNT_W;

	// Longest limit must fit the counter, or the clamp limit would be truncated
	if (CYC_PER_MS < 1 || bst_pkg::CLAMP3_MS * CYC_PER_MS >= 2 ** CW)
	begin : g_bad_rate
		$error("clamp counter too narrow for CYC_PER_MS");
	end

	function automatic logic [CW-1:0] limit_of(input logic [1:0] c);
		case (c)
			2'h1: limit_of = CW'(bst_pkg::CLAMP1_MS * CYC_PER_MS);
			2'h2: limit_of = CW'(bst_pkg::CLAMP2_MS * CYC_PER_MS);
			default: limit_of = CW'(bst_pkg::CLAMP3_MS * CYC_PER_MS);
		endcase
	endfunction : limit_of

	bst_pkg::bst_od_state_t state;
	bst_pkg::bst_od_state_t next_state;
	logic [CW-1:0]          count;
	logic [CW-1:0]          next_count;

	// Clamp ignored in calibration and diagnostics
	wire logic clamp_en = (clamp_code != 2'h0) && !calib_active
		&& !diag_active;
	wire logic expired  = (count >= limit_of(clamp_code) - CW'(1));

	always_comb
	begin
		next_state = state;
		next_count = count;
		case (state)
			bst_pkg::BST_IDLE:
			begin
				next_count = '0;
				if (od_active && clamp_en)
					next_state = bst_pkg::BST_RUN;
			end
			bst_pkg::BST_RUN:
			begin
				next_count = count + CW'(1);
				if (!od_active || !clamp_en)
					next_state = bst_pkg::BST_IDLE;
				else if (expired)
					next_state = bst_pkg::BST_CLAMP;
			end
			default:
			begin
				if (!od_active || !clamp_en)
					next_state = bst_pkg::BST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state <= bst_pkg::BST_IDLE;
			count <= '0;
		end
		else
		begin
			state <= next_state;
			count <= next_count;
		end
	end

	// Immediate, not aligned to a zero crossing
	assign rated_clamp = (state == bst_pkg::BST_CLAMP);
endmodule : bst_od_clamp
`default_nettype wire

// *** rtl/bst_pkg.sv ***
package bst_pkg;
	// Register offsets
	localparam logic [7:0] SENSE_WAIT_TIMES_OFS    = 8'h28;
	localparam logic [7:0] DRIVE_SAMPLE_TIMING_OFS = 8'h29;
	// Field positions
	localparam int SETTLE_LSB   = 4;
	localparam int DISCH_LSB    = 0;
	localparam int CLAMP_LSB    = 4;
	localparam int SAMPLE_LSB   = 2;
	localparam int ZC_LSB       = 0;
	// Values after reset
	localparam logic [3:0] SETTLE_RST = 4'h1;
	localparam logic [3:0] DISCH_RST  = 4'h1;
	localparam logic [1:0] CLAMP_RST  = 2'h0;
	localparam logic [1:0] SAMPLE_RST = 2'h3;
	localparam logic [1:0] ZC_RST     = 2'h0;
	// Clock
	localparam int CLK_MHZ = 40;
	// Overdrive clamp limits in ms, and cycles per ms
	localparam int CLAMP1_MS = 25;
	localparam int CLAMP2_MS = 50;
	localparam int CLAMP3_MS = 100;
	localparam int CYC_PER_MS = CLK_MHZ * 1000;
	// Zero-cross window in us
	localparam int ZC0_US = 100;
	localparam int ZC1_US = 200;
	localparam int ZC2_US = 300;
	localparam int ZC3_US = 390;
	localparam int CNT_W = 23;
	typedef enum logic [1:0] {
		BST_IDLE,
		BST_RUN,
		BST_CLAMP
	} bst_od_state_t;
endpackage : bst_pkg

// *** rtl/bst_timing_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Settle-wait code sits in bits 7-4 at sense_wait_times, reset 1.
// - Codes 0-3 give 15/25/50/75 us for LRA, 45/75/150/225 us for ERM.
// - Codes 4-15 give 90..285 us for LRA and are undefined for ERM.
// - Discharge-wait code sits in bits 3-0 at sense_wait_times, reset 1, same map.
// - Overdrive clamp code sits in bits 5-4 at drive_sample_timing, reset 0.
// - Clamp code 0 is automatic overdrive; 1-3 limit it to 25/50/100 ms.
// - On expiry the rated-voltage clamp applies at once.
// - Calibration and diagnostics ignore the clamp code.
// - Sample-offset code sits in bits 3-2 at drive_sample_timing, reset 3.
// - Zero-cross window sits in bits 1-0 at drive_sample_timing, reset 0: 100-390 us.
module bst_timing_regs
#(
	// Cycles per millisecond of the clamp timer
	parameter int CYC_PER_MS = bst_pkg::CYC_PER_MS
)
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic        erm_sel,
	input  wire logic        calib_active,
	input  wire logic        diag_active,
	input  wire logic        od_active,
	output logic      [3:0]  settle_wait_code,
	output logic      [3:0]  discharge_wait_code,
	output logic      [1:0]  overdrive_clamp_code,
	output logic      [1:0]  sample_offset_code,
	output logic      [1:0]  zero_cross_window_code,
	output logic      [15:0] settle_wait_cycles,
	output logic      [15:0] discharge_wait_cycles,
	output logic             wait_code_invalid,
	output logic      [15:0] zero_cross_window_cycles,
	output logic             rated_clamp
);
	// Reserved bits 7-6 at drive_sample_timing are writable and read back
	logic [1:0] rsvd29;

	wire logic sel28 = (reg_addr == bst_pkg::SENSE_WAIT_TIMES_OFS);
	wire logic sel29 = (reg_addr == bst_pkg::DRIVE_SAMPLE_TIMING_OFS);
	wire logic wr28  = reg_wr && sel28;
	wire logic wr29  = reg_wr && sel29;

	wire logic [7:0] rd_mux = sel28 ? {settle_wait_code, discharge_wait_code}
		: sel29 ? {rsvd29, overdrive_clamp_code, sample_offset_code,
		zero_cross_window_code} : 8'h00;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			settle_wait_code    <= bst_pkg::SETTLE_RST;
			discharge_wait_code <= bst_pkg::DISCH_RST;
		end
		else if (wr28)
		begin
			settle_wait_code    <= reg_wdata[bst_pkg::SETTLE_LSB +: 4];
			discharge_wait_code <= reg_wdata[bst_pkg::DISCH_LSB +: 4];
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rsvd29                 <= 2'h0;
			overdrive_clamp_code   <= bst_pkg::CLAMP_RST;
			sample_offset_code     <= bst_pkg::SAMPLE_RST;
			zero_cross_window_code <= bst_pkg::ZC_RST;
		end
		else if (wr29)
		begin
			rsvd29                 <= reg_wdata[7:6];
			overdrive_clamp_code   <= reg_wdata[bst_pkg::CLAMP_LSB +: 2];
			sample_offset_code     <= reg_wdata[bst_pkg::SAMPLE_LSB +: 2];
			zero_cross_window_code <= reg_wdata[bst_pkg::ZC_LSB +: 2];
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rd_mux;
		else
			reg_rdata <= 8'h00;
	end

	logic inv_settle;
	logic inv_disch;

	bst_wait_lut u_settle
	(
		.code    (settle_wait_code),
		.erm_sel (erm_sel),
		.cycles  (settle_wait_cycles),
		.invalid (inv_settle)
	);

	bst_wait_lut u_disch
	(
		.code    (discharge_wait_code),
		.erm_sel (erm_sel),
		.cycles  (discharge_wait_cycles),
		.invalid (inv_disch)
	);

	assign wait_code_invalid = inv_settle || inv_disch;

	always_comb
	begin
		case (zero_cross_window_code)
			2'h0: zero_cross_window_cycles = 16'(bst_pkg::ZC0_US * bst_pkg::CLK_MHZ);
			2'h1: zero_cross_window_cycles = 16'(bst_pkg::ZC1_US * bst_pkg::CLK_MHZ);
			2'h2: zero_cross_window_cycles = 16'(bst_pkg::ZC2_US * bst_pkg::CLK_MHZ);
			default: zero_cross_window_cycles = 16'(bst_pkg::ZC3_US * bst_pkg::CLK_MHZ);
		endcase
	end

	bst_od_clamp
	#(
		.CYC_PER_MS (CYC_PER_MS)
	)
	u_clamp
	(
		.clk          (clk),
		.rst_b        (rst_b),
		.clamp_code   (overdrive_clamp_code),
		.calib_active (calib_active),
		.diag_active  (diag_active),
		.od_active    (od_active),
		.rated_clamp  (rated_clamp)
	);
endmodule : bst_timing_regs
`default_nettype wire

// *** rtl/bst_wait_lut.sv ***
`timescale 1ns/10ps
`default_nettype none
module bst_wait_lut
(
	input  wire logic [3:0]  code,
	input  wire logic        erm_sel,
	output logic      [15:0] cycles,
	output logic             invalid
);
	// Cycles at 40 MHz: us * 40
	function automatic logic [15:0] us_cyc(input int us);
		us_cyc = 16'(us * bst_pkg::CLK_MHZ);
	endfunction : us_cyc

	logic [15:0] lra_cyc;
	logic [15:0] erm_cyc;

	always_comb
	begin
		case (code)
			4'h0: lra_cyc = us_cyc(15);
			4'h1: lra_cyc = us_cyc(25);
			4'h2: lra_cyc = us_cyc(50);
			4'h3: lra_cyc = us_cyc(75);
			4'h4: lra_cyc = us_cyc(90);
			4'h5: lra_cyc = us_cyc(105);
			4'h6: lra_cyc = us_cyc(120);
			4'h7: lra_cyc = us_cyc(135);
			4'h8: lra_cyc = us_cyc(150);
			4'h9: lra_cyc = us_cyc(165);
			4'hA: lra_cyc = us_cyc(180);
			4'hB: lra_cyc = us_cyc(195);
			4'hC: lra_cyc = us_cyc(210);
			4'hD: lra_cyc = us_cyc(235);
			4'hE: lra_cyc = us_cyc(260);
			default: lra_cyc = us_cyc(285);
		endcase
	end

	always_comb
	begin
		case (code)
			4'h0: erm_cyc = us_cyc(45);
			4'h1: erm_cyc = us_cyc(75);
			4'h2: erm_cyc = us_cyc(150);
			default: erm_cyc = us_cyc(225);
		endcase
	end

	// No ERM time above code 3; clip to the longest and flag it
	assign invalid = erm_sel && (code > 4'h3);
	assign cycles  = erm_sel ? erm_cyc : lra_cyc;
endmodule : bst_wait_lut
`default_nettype wire

// *** verification/bst_timing_regs_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module bst_timing_regs_asserts
(
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic        erm_sel,
	input wire logic        calib_active,
	input wire logic        diag_active,
	input wire logic        od_active,
	input wire logic [3:0]  settle_wait_code,
	input wire logic [3:0]  discharge_wait_code,
	input wire logic [1:0]  overdrive_clamp_code,
	input wire logic [1:0]  sample_offset_code,
	input wire logic        wait_code_invalid,
	input wire logic [1:0]  zero_cross_window_code,
	input wire logic [15:0] zero_cross_window_cycles,
	input wire logic        rated_clamp
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire logic w28 = reg_wr && (reg_addr == bst_pkg::SENSE_WAIT_TIMES_OFS);
	wire logic w29 = reg_wr && (reg_addr == bst_pkg::DRIVE_SAMPLE_TIMING_OFS);
	wire logic r28 = reg_rd && (reg_addr == bst_pkg::SENSE_WAIT_TIMES_OFS);
	a_settle_write: assert property (
		w28 |=> settle_wait_code == $past(reg_wdata[7:4]))
		else $error("settle code not written");
	a_disch_write: assert property (
		w28 |=> discharge_wait_code == $past(reg_wdata[3:0]))
		else $error("discharge code not written");
	a_clamp_write: assert property (
		w29 |=> overdrive_clamp_code == $past(reg_wdata[5:4]))
		else $error("clamp code not written");
	a_sample_write: assert property (
		w29 |=> sample_offset_code == $past(reg_wdata[3:2]))
		else $error("sample code not written");
	a_zc_write: assert property (
		w29 |=> zero_cross_window_code == $past(reg_wdata[1:0]))
		else $error("window code not written");
	a_read_back: assert property (
		r28 |=> reg_rdata == {settle_wait_code, discharge_wait_code})
		else $error("read data wrong");
	a_read_idle: assert property (
		!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not idle");
	a_erm_invalid: assert property (
		wait_code_invalid == (erm_sel && (settle_wait_code > 4'h3
		|| discharge_wait_code > 4'h3)))
		else $error("invalid flag wrong");
	a_zc_cycles: assert property (
		zero_cross_window_code == 2'h3 |-> zero_cross_window_cycles == 16'h3CF0)
		else $error("window count wrong");
	a_clamp_off: assert property (
		overdrive_clamp_code == 2'h0 || calib_active || diag_active
		|=> !rated_clamp)
		else $error("clamp while disabled");
	a_clamp_drop: assert property (
		!od_active |=> !rated_clamp)
		else $error("clamp outside overdrive");
	c_write: cover property (w29);
	c_erm: cover property (wait_code_invalid);
	c_calib: cover property (calib_active && overdrive_clamp_code != 2'h0);
	c_clamp: cover property (rated_clamp);
endmodule : bst_timing_regs_asserts
bind bst_timing_regs bst_timing_regs_asserts bst_timing_regs_asserts_i
(
	.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.erm_sel, .calib_active, .diag_active, .od_active, .settle_wait_code,
	.discharge_wait_code, .overdrive_clamp_code, .sample_offset_code,
	.wait_code_invalid, .zero_cross_window_code, .zero_cross_window_cycles,
	.rated_clamp
);
`default_nettype wire

// *** verification/bst_timing_regs_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module bst_timing_regs_tb_top;
	logic clk, rst_b, reg_wr, reg_rd, erm_sel, calib_active, diag_active;
	logic od_active, wait_code_invalid, rated_clamp;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [3:0] settle_wait_code, discharge_wait_code;
	logic [1:0] overdrive_clamp_code, sample_offset_code, zero_cross_window_code;
	logic [15:0] settle_wait_cycles, discharge_wait_cycles, zero_cross_window_cycles;
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;
	int lra[16] = '{15, 25, 50, 75, 90, 105, 120, 135, 150, 165, 180, 195, 210, 235, 260, 285};
	int erm[4] = '{45, 75, 150, 225};
	int zc[4] = '{100, 200, 300, 390};
	// Shortened millisecond so clamp expiry fits in the run
	localparam int TB_CYC = 40;
	int clamp_ms[4] = '{0, 25, 50, 100};
	localparam logic [15:0] FIELDS_RST = {2'h0, bst_pkg::SETTLE_RST,
		bst_pkg::DISCH_RST, bst_pkg::CLAMP_RST, bst_pkg::SAMPLE_RST,
		bst_pkg::ZC_RST};
	wire logic [15:0] fields = {2'h0, settle_wait_code, discharge_wait_code,
		overdrive_clamp_code, sample_offset_code, zero_cross_window_code};
	bst_timing_regs #(.CYC_PER_MS(TB_CYC)) bst_timing_regs_i (.clk, .rst_b,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .erm_sel,
		.calib_active, .diag_active, .od_active, .settle_wait_code,
		.discharge_wait_code, .overdrive_clamp_code, .sample_offset_code,
		.zero_cross_window_code, .settle_wait_cycles, .discharge_wait_cycles,
		.wait_code_invalid, .zero_cross_window_cycles, .rated_clamp);
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop
	task automatic chk16(string nm, logic [15:0] e, logic [15:0] g);
		num_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk16
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk16("rdata", {8'h00, e}, {8'h00, reg_rdata});
	endtask : rd
	task automatic clamp_time(logic [1:0] code, int lim);
		@(posedge clk) od_active <= 1'b0;
		wr(8'h29, {2'h0, code, 4'h0});
		@(posedge clk) od_active <= 1'b1;
		repeat (lim) @(posedge clk);
		#1;
		chk16("clamp_early", 16'h0000, {15'h0000, rated_clamp});
		@(posedge clk);
		#1;
		chk16("clamp_time", 16'h0001, {15'h0000, rated_clamp});
	endtask : clamp_time
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Whole run is about ten thousand four hundred cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			report_and_stop();
		end
	end
	initial
	begin
		{rst_b, reg_wr, reg_rd, erm_sel, calib_active, diag_active, od_active} = 7'h00;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		rd(8'h28, 8'h11);
		rd(8'h29, 8'h0C);
		chk16("fields", FIELDS_RST, fields);
		chk16("settle", 16'(lra[1] * 40), settle_wait_cycles);
		$display("test reset done");
		for (int c = 0; c < 16; c++)
		begin
			wr(8'h28, {c[3:0], 4'hF - c[3:0]});
			chk16("settle", 16'(lra[c] * 40), settle_wait_cycles);
			chk16("disch", 16'(lra[15 - c] * 40), discharge_wait_cycles);
		end
		rd(8'h28, 8'hF0);
		$display("test lra done");
		@(posedge clk) erm_sel <= 1'b1;
		for (int c = 0; c < 4; c++)
		begin
			wr(8'h28, {c[3:0], c[3:0]});
			chk16("erm", 16'(erm[c] * 40), discharge_wait_cycles);
			chk16("inval", 16'h0000, {15'h0000, wait_code_invalid});
		end
		wr(8'h28, 8'h43);
		chk16("inval", 16'h0001, {15'h0000, wait_code_invalid});
		$display("test erm done");
		for (int c = 0; c < 4; c++)
		begin
			wr(8'h29, {6'h3F, c[1:0]});
			chk16("zc", 16'(zc[c] * 40), zero_cross_window_cycles);
		end
		rd(8'h29, 8'hFF);
		chk16("fields", {2'h0, 4'h4, 4'h3, 2'h3, 2'h3, 2'h3}, fields);
		wr(8'h2A, 8'h5A);
		rd(8'h2A, 8'h00);
		rd(8'h28, 8'h43);
		$display("test window done");
		wr(8'h29, 8'h10);
		@(posedge clk) calib_active <= 1'b1;
		@(posedge clk) od_active <= 1'b1;
		repeat (1100) @(posedge clk);
		#1;
		chk16("clamp_cal", 16'h0000, {15'h0000, rated_clamp});
		@(posedge clk);
		calib_active <= 1'b0;
		diag_active <= 1'b1;
		repeat (1100) @(posedge clk);
		#1;
		chk16("clamp_diag", 16'h0000, {15'h0000, rated_clamp});
		wr(8'h29, 8'h00);
		@(posedge clk) diag_active <= 1'b0;
		repeat (1100) @(posedge clk);
		#1;
		chk16("clamp_off", 16'h0000, {15'h0000, rated_clamp});
		for (int c = 1; c < 4; c++)
			clamp_time(c[1:0], clamp_ms[c] * TB_CYC);
		$display("test clamp done");
		// Reset in mid-run while the clamp is applied
		@(posedge clk) rst_b <= 1'b0;
		@(posedge clk) rst_b <= 1'b1;
		#1;
		chk16("clamp_rst", 16'h0000, {15'h0000, rated_clamp});
		chk16("fields", FIELDS_RST, fields);
		rd(8'h28, 8'h11);
		rd(8'h29, 8'h0C);
		$display("test second reset done");
		report_and_stop();
	end
endmodule : bst_timing_regs_tb_top
`default_nettype wire
